// ==== hdl/tcs_pkg.sv ====
// Constants shared by the signaling change and frame status register block.
package tcs_pkg;
    localparam int TCS_SLOTS = 24;
    localparam int TCS_SLOT_W = 5;
    localparam int TCS_SIG_W = 4;
    localparam int TCS_ADDR_W = 16;
    localparam int TCS_IDX_W = 14;
    localparam int TCS_DATA_W = 32;
    localparam int TCS_REG_W = 8;
    localparam int TCS_IRQ_W = 3;

    // Register indices; the byte address is four times the index.
    localparam logic [TCS_IDX_W-1:0] TCS_IDX_CHG0 = 14'h010d;
    localparam logic [TCS_IDX_W-1:0] TCS_IDX_CHG1 = 14'h010e;
    localparam logic [TCS_IDX_W-1:0] TCS_IDX_CHG2 = 14'h010f;
    localparam logic [TCS_IDX_W-1:0] TCS_IDX_FRAME = 14'h0113;
    localparam logic [TCS_IDX_W-1:0] TCS_IDX_CTRL = 14'h0120;
    localparam logic [TCS_IDX_W-1:0] TCS_IDX_IRQ_STAT = 14'h0121;
    localparam logic [TCS_IDX_W-1:0] TCS_IDX_IRQ_MASK = 14'h0122;

    // Field positions.
    localparam int TCS_FRAME_IN_BIT = 7;
    localparam int TCS_CTRL_CAS_EN_BIT = 0;
    localparam int TCS_IRQ_CHG_BIT = 0;
    localparam int TCS_IRQ_LOF_BIT = 1;
    localparam int TCS_IRQ_REGAIN_BIT = 2;

    // Reset values.
    localparam logic [TCS_REG_W-1:0] TCS_CHG_RESET = 8'h00;
    localparam logic TCS_IN_FRAME_RESET = 1'b0;
    localparam logic TCS_CAS_EN_RESET = 1'b0;
    localparam logic [TCS_IRQ_W-1:0] TCS_IRQ_RESET = 3'h0;
    localparam logic [TCS_SIG_W-1:0] TCS_SIG_RESET = 4'h0;
endpackage

// ==== hdl/tcs_flag_if.sv ====
// Interface between the bus side and the per-slot change detector.
`timescale 1ns/1ps
`default_nettype none
interface tcs_flag_if;
    import tcs_pkg::*;
    logic sig_valid;
    logic [TCS_SLOT_W-1:0] sig_slot;
    logic [TCS_SIG_W-1:0] sig_data;
    logic enable;
    logic [TCS_SLOTS-1:0] rd_clear;
    logic [TCS_SLOTS-1:0] flags;
    logic new_event;
    modport det (
        input sig_valid, sig_slot, sig_data, enable, rd_clear,
        output flags, new_event
    );
    modport ctl (
        output sig_valid, sig_slot, sig_data, enable, rd_clear,
        input flags, new_event
    );
endinterface
`default_nettype wire

// ==== hdl/tcs_change_detect.sv ====
// Per-slot signaling change detector with sticky flags.
`timescale 1ns/1ps
`default_nettype none
module tcs_change_detect
    import tcs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    tcs_flag_if.det fi
);
    logic [TCS_SLOTS-1:0] set_vec;

    for (genvar g = 0; g < TCS_SLOTS; g++) begin : g_slot
        logic [TCS_SIG_W-1:0] last_r;
        logic [TCS_SIG_W-1:0] last_nxt;
        logic flag_r;
        logic flag_nxt;
        logic hit;
        always_comb begin
            hit = fi.enable && fi.sig_valid && (fi.sig_slot == TCS_SLOT_W'(g));
            last_nxt = hit ? fi.sig_data : last_r;
            set_vec[g] = hit && (fi.sig_data != last_r);
            // Set wins over a read clear in the same cycle.
            flag_nxt = fi.enable && (set_vec[g] || (flag_r && !fi.rd_clear[g]));
        end
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                last_r <= TCS_SIG_RESET;
                flag_r <= 1'b0;
            end else begin
                last_r <= last_nxt;
                flag_r <= flag_nxt;
            end
        end
        assign fi.flags[g] = flag_r;
    end

    assign fi.new_event = |set_vec;

    flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        set_vec[0] |=> fi.flags[0]) else $error("slot 0 change not flagged");
    flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        fi.flags[5] && !fi.rd_clear[5] && fi.enable |=> fi.flags[5])
        else $error("flag lost without read");
    flag_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        !fi.enable |=> fi.flags == '0) else $error("flags active while disabled");
endmodule
`default_nettype wire

// ==== hdl/tcs_regs.sv ====
// APB register bank for signaling change flags, frame state and interrupts.
`timescale 1ns/1ps
`default_nettype none
module tcs_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [tcs_pkg::TCS_ADDR_W-1:0] paddr,
    input wire logic [tcs_pkg::TCS_DATA_W-1:0] pwdata,
    output logic [tcs_pkg::TCS_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sig_valid,
    input wire logic [tcs_pkg::TCS_SLOT_W-1:0] sig_slot,
    input wire logic [tcs_pkg::TCS_SIG_W-1:0] sig_data,
    input wire logic in_frame,
    output logic irq
);
    import tcs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Change detector.
    tcs_flag_if fi ();
    logic cas_en_r;
    logic cas_en_nxt;
    logic [TCS_SLOTS-1:0] rd_clear;

    assign fi.sig_valid = sig_valid;
    assign fi.sig_slot = sig_slot;
    assign fi.sig_data = sig_data;
    assign fi.enable = cas_en_r;
    assign fi.rd_clear = rd_clear;

    tcs_change_detect u_det (
        .pclk(pclk),
        .presetn(presetn),
        .fi(fi)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode.
    logic [TCS_IDX_W-1:0] idx;
    logic hit_chg0;
    logic hit_chg1;
    logic hit_chg2;
    logic hit_frame;
    logic hit_ctrl;
    logic hit_stat;
    logic hit_mask;
    logic mapped;
    logic done;
    logic wr_done;
    logic rd_done;

    always_comb begin
        idx = paddr[TCS_ADDR_W-1:2];
        hit_chg0 = (idx == TCS_IDX_CHG0) && (paddr[1:0] == 2'h0);
        hit_chg1 = (idx == TCS_IDX_CHG1) && (paddr[1:0] == 2'h0);
        hit_chg2 = (idx == TCS_IDX_CHG2) && (paddr[1:0] == 2'h0);
        hit_frame = (idx == TCS_IDX_FRAME) && (paddr[1:0] == 2'h0);
        hit_ctrl = (idx == TCS_IDX_CTRL) && (paddr[1:0] == 2'h0);
        hit_stat = (idx == TCS_IDX_IRQ_STAT) && (paddr[1:0] == 2'h0);
        hit_mask = (idx == TCS_IDX_IRQ_MASK) && (paddr[1:0] == 2'h0);
        mapped = hit_chg0 | hit_chg1 | hit_chg2 | hit_frame | hit_ctrl | hit_stat | hit_mask;
        done = psel && penable && pready;
        wr_done = done && pwrite && mapped;
        rd_done = done && !pwrite && mapped;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data mapping: lowest slot of each group sits in bit 7.
    logic [TCS_REG_W-1:0] chg_byte [3];
    logic [TCS_DATA_W-1:0] rd_val;
    logic in_frame_r;
    logic [TCS_IRQ_W-1:0] stat_r;
    logic [TCS_IRQ_W-1:0] mask_r;

    always_comb begin
        for (int r = 0; r < 3; r++) begin
            for (int b = 0; b < TCS_REG_W; b++) begin
                chg_byte[r][TCS_REG_W-1-b] = fi.flags[r*TCS_REG_W+b];
            end
        end
        rd_val = '0;
        if (hit_chg0) begin
            rd_val[TCS_REG_W-1:0] = chg_byte[0];
        end else if (hit_chg1) begin
            rd_val[TCS_REG_W-1:0] = chg_byte[1];
        end else if (hit_chg2) begin
            rd_val[TCS_REG_W-1:0] = chg_byte[2];
        end else if (hit_frame) begin
            rd_val[TCS_FRAME_IN_BIT] = in_frame_r;
        end else if (hit_ctrl) begin
            rd_val[TCS_CTRL_CAS_EN_BIT] = cas_en_r;
        end else if (hit_stat) begin
            rd_val[TCS_IRQ_W-1:0] = stat_r;
        end else if (hit_mask) begin
            rd_val[TCS_IRQ_W-1:0] = mask_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus answer: one wait state, data and error come from flops.
    logic pready_nxt;
    logic [TCS_DATA_W-1:0] prdata_nxt;
    logic pslverr_nxt;

    always_comb begin
        pready_nxt = psel && penable && !pready;
        prdata_nxt = pready_nxt && !pwrite ? rd_val : '0;
        pslverr_nxt = pready_nxt && !mapped;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end else begin
            pready <= pready_nxt;
            prdata <= prdata_nxt;
            pslverr <= pslverr_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read clear at the completing edge: only flags that the read returned are cleared,
    // so a change that lands after the data were taken is kept for the next read.
    always_comb begin
        rd_clear = '0;
        for (int b = 0; b < TCS_REG_W; b++) begin
            if (rd_done && hit_chg0) begin
                rd_clear[b] = prdata[TCS_REG_W-1-b];
            end
            if (rd_done && hit_chg1) begin
                rd_clear[TCS_REG_W+b] = prdata[TCS_REG_W-1-b];
            end
            if (rd_done && hit_chg2) begin
                rd_clear[2*TCS_REG_W+b] = prdata[TCS_REG_W-1-b];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Control, frame state and interrupt registers.
    logic in_frame_nxt;
    logic [TCS_IRQ_W-1:0] stat_nxt;
    logic [TCS_IRQ_W-1:0] mask_nxt;
    logic [TCS_IRQ_W-1:0] ev;
    logic irq_nxt;

    always_comb begin
        in_frame_nxt = in_frame;
        cas_en_nxt = cas_en_r;
        mask_nxt = mask_r;
        if (wr_done && hit_ctrl) begin
            cas_en_nxt = pwdata[TCS_CTRL_CAS_EN_BIT];
        end
        if (wr_done && hit_mask) begin
            mask_nxt = pwdata[TCS_IRQ_W-1:0];
        end
        ev = '0;
        ev[TCS_IRQ_CHG_BIT] = fi.new_event;
        ev[TCS_IRQ_LOF_BIT] = in_frame_r && !in_frame;
        ev[TCS_IRQ_REGAIN_BIT] = !in_frame_r && in_frame;
        stat_nxt = stat_r;
        if (wr_done && hit_stat) begin
            stat_nxt = stat_r & ~pwdata[TCS_IRQ_W-1:0];
        end
        stat_nxt = stat_nxt | ev;
        irq_nxt = |(stat_nxt & mask_nxt);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_frame_r <= TCS_IN_FRAME_RESET;
            cas_en_r <= TCS_CAS_EN_RESET;
            stat_r <= TCS_IRQ_RESET;
            mask_r <= TCS_IRQ_RESET;
            irq <= 1'b0;
        end else begin
            in_frame_r <= in_frame_nxt;
            cas_en_r <= cas_en_nxt;
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
            irq <= irq_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.
    chg0_order_a: assert property (@(posedge pclk) disable iff (!presetn)
        hit_chg0 |-> rd_val[7] == fi.flags[0] && rd_val[0] == fi.flags[7])
        else $error("slot order wrong in first change register");
    chg1_order_a: assert property (@(posedge pclk) disable iff (!presetn)
        hit_chg1 |-> rd_val[7] == fi.flags[8] && rd_val[0] == fi.flags[15])
        else $error("slot order wrong in second change register");
    chg2_order_a: assert property (@(posedge pclk) disable iff (!presetn)
        hit_chg2 |-> rd_val[7] == fi.flags[16] && rd_val[0] == fi.flags[23])
        else $error("slot order wrong in third change register");
    read_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        rd_done && hit_chg1 && !fi.new_event |=>
        (chg_byte[1] & $past(prdata[TCS_REG_W-1:0])) == 8'h00)
        else $error("change flags not cleared by read");
    late_change_a: assert property (@(posedge pclk) disable iff (!presetn)
        rd_done && hit_chg0 && fi.flags[0] && !prdata[7] |=> fi.flags[0])
        else $error("unreported change lost by read");
    frame_track_a: assert property (@(posedge pclk) disable iff (!presetn)
        in_frame ##1 in_frame |-> in_frame_r) else $error("in-frame not shown");
    frame_lof_a: assert property (@(posedge pclk) disable iff (!presetn)
        !in_frame |=> !in_frame_r) else $error("loss of frame not shown");
    frame_rsvd_a: assert property (@(posedge pclk) disable iff (!presetn)
        hit_frame |-> rd_val[6:0] == 7'h00) else $error("reserved bits not zero");
    cas_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        !cas_en_r |-> !fi.new_event) else $error("change seen while disabled");
    slave_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable ##1 psel && penable |-> !pready ##1 pready)
        else $error("answer not after one wait state");
    irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        |(stat_r & mask_r) |-> irq) else $error("interrupt not raised");
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
// Self-checking testbench for the signaling change and frame state register block.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import tcs_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [TCS_ADDR_W-1:0] paddr = '0;
    logic [TCS_DATA_W-1:0] pwdata = '0;
    logic [TCS_DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic sig_valid = 1'b0;
    logic [TCS_SLOT_W-1:0] sig_slot = '0;
    logic [TCS_SIG_W-1:0] sig_data = '0;
    logic in_frame = 1'b0;
    logic irq;
    int err_count = 0;
    int compares = 0;
    logic [31:0] rd;
    logic er;
    logic [TCS_IDX_W-1:0] idx [7];
    tcs_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sig_valid(sig_valid), .sig_slot(sig_slot), .sig_data(sig_data),
        .in_frame(in_frame), .irq(irq));
    always #5 pclk = ~pclk;
    ////////////////////////////////////////////////////////////////////////////
    // Compares a seen value with the expected one and counts both outcomes.
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One APB transfer; waits for pready and takes data and error at that edge.
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        if (n >= 50) err_count++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Presents one strobe of signaling bits for a slot.
    task automatic sig(input int s, input logic [3:0] d);
        @(posedge pclk);
        sig_valid <= 1'b1;
        sig_slot <= s[TCS_SLOT_W-1:0];
        sig_data <= d;
        @(posedge pclk);
        sig_valid <= 1'b0;
    endtask
    task automatic rdr(input logic [TCS_IDX_W-1:0] i, input logic [31:0] exp, input string n);
        apb(1'b0, {i, 2'b00}, '0, rd, er);
        chk(n, rd, exp);
        chk("pslverr", {31'h0, er}, 32'h0);
    endtask
    task automatic end_sim;
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Watchdog cuts a hang short.
    initial begin
        #200000;
        err_count++;
        end_sim();
    end
    initial begin
        idx = '{TCS_IDX_CHG0, TCS_IDX_CHG1, TCS_IDX_CHG2, TCS_IDX_FRAME, TCS_IDX_CTRL,
                TCS_IDX_IRQ_STAT, TCS_IDX_IRQ_MASK};
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values of every register.
        foreach (idx[k]) rdr(idx[k], 32'h0, "reset value");
        // Changes are ignored while signaling is disabled.
        sig(0, 4'ha);
        rdr(TCS_IDX_CHG0, 32'h0, "cas off");
        apb(1'b1, {TCS_IDX_CTRL, 2'b00}, 32'h1, rd, er);
        // Each slot lands in its own register bit and clears on the read.
        for (int s = 0; s < 24; s++) begin
            sig(s, 4'h3);
            rdr(TCS_IDX_CHG0 + s / 8, 32'h80 >> (s % 8), "slot bit");
        end
        for (int k = 0; k < 3; k++) rdr(idx[k], 32'h0, "cleared");
        sig(5, 4'h3);
        rdr(TCS_IDX_CHG0, 32'h0, "no change");
        // A change that lands after the read data were taken survives that read.
        fork
            apb(1'b0, {TCS_IDX_CHG0, 2'b00}, '0, rd, er);
            begin
                @(posedge pclk);
                sig(1, 4'h5);
            end
        join
        chk("read before change", rd, 32'h0);
        rdr(TCS_IDX_CHG0, 32'h40, "change kept");
        // Writes to change registers are ignored.
        sig(9, 4'h6);
        apb(1'b1, {TCS_IDX_CHG1, 2'b00}, 32'h0, rd, er);
        rdr(TCS_IDX_CHG1, 32'h40, "write ignored");
        // Interrupt raised, masked and cleared.
        rdr(TCS_IDX_IRQ_STAT, 32'h1, "irq status");
        chk("irq masked", {31'h0, irq}, 32'h0);
        apb(1'b1, {TCS_IDX_IRQ_MASK, 2'b00}, 32'h7, rd, er);
        repeat (2) @(posedge pclk);
        chk("irq on", {31'h0, irq}, 32'h1);
        apb(1'b1, {TCS_IDX_IRQ_STAT, 2'b00}, 32'h1, rd, er);
        repeat (2) @(posedge pclk);
        chk("irq off", {31'h0, irq}, 32'h0);
        // Frame state follows the framer and ignores writes.
        in_frame <= 1'b1;
        repeat (3) @(posedge pclk);
        rdr(TCS_IDX_FRAME, 32'h80, "in frame");
        apb(1'b1, {TCS_IDX_FRAME, 2'b00}, 32'h7f, rd, er);
        rdr(TCS_IDX_FRAME, 32'h80, "frame ro");
        in_frame <= 1'b0;
        repeat (3) @(posedge pclk);
        rdr(TCS_IDX_FRAME, 32'h0, "lof");
        rdr(TCS_IDX_IRQ_STAT, 32'h6, "frame events");
        // Unmapped and misaligned addresses are refused.
        apb(1'b0, 16'h0000, '0, rd, er);
        chk("unmapped err", {31'h0, er}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        apb(1'b0, 16'h0435, '0, rd, er);
        chk("misaligned err", {31'h0, er}, 32'h1);
        // Turning signaling off drops pending flags.
        sig(2, 4'h9);
        apb(1'b1, {TCS_IDX_CTRL, 2'b00}, 32'h0, rd, er);
        rdr(TCS_IDX_CHG0, 32'h0, "cas disabled");
        end_sim();
    end
endmodule
`default_nettype wire
